// >>> pib_bridge.sv
// Configuration registers, ISA I/O recovery and ISA-master forwarding decode of the bridge.
`include "pib_params.svh"
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RQ1 - Header layout register reads 00h; writes are ignored.
// RQ2 - At least 3.5 ISA clocks between back-to-back PCI-initiated ISA I/O commands.
// RQ3 - No recovery between sub-cycles of one assembled or split access.
// RQ4 - ISA clock is the PCI clock divided by four; divider value 1 reserved.
// RQ5 - Bit 6 set applies programmed 8-bit recovery, else default 3.5 clocks.
// RQ6 - Bits 5-3 add 1,2,3,4,4,6,7 or 8 (for 000) ISA clocks.
// RQ7 - Bit 2 set applies programmed 16-bit recovery, else default 3.5 clocks.
// RQ8 - Bits 1-0 give 16-bit recovery 1,2,3 or 4 (for 00) clocks.
// RQ9 - Control bit 7 passive release, bit 0 refresh option, both reset off.
// RQ10 - Control bit 1 stretches the refresh interval to 208 us.
// RQ11 - Error status bit 2 reads the inverse of the channel-check pin.
// RQ12 - Channel-check status pulses system error when the driver is enabled.
// RQ13 - Illegal I/O byte lanes set status bit 0, target abort, system error.
// RQ14 - Ceiling bits 7-4 set top of memory as n+1 Mbytes.
// RQ15 - Software sets 15 Mbytes when a hole sits between 15 and 16 Mbytes.
// RQ16 - E0000h-EFFFFh forwarded to PCI only when ceiling bit 3 is set.
// RQ17 - A0000h-BFFFFh forwarded to PCI only when ceiling bit 2 is set.
// RQ18 - 512K-640K forwarded to PCI only when ceiling bit 1 is set.
// RQ19 - From top of memory to 128 Mbyte cycles stay on ISA.
// RQ20 - From 1 Mbyte to top of memory cycles are forwarded to PCI.
// RQ21 - 0-512K, 768K-E0000h and F0000h-1M always forwarded to PCI.
// RQ22 - ISA master or DMA cycles never reach host or PCI I/O space.
// RQ23 - Command bit 8 enables the system-error driver and gates every pulse.
// RQ24 - Status bit 14 set on each system-error pulse; write 1 clears.
// RQ25 - Status bit 11 set on each target abort; write 1 clears.
// RQ26 - Reserved bits read zero and ignore writes.
// RQ27 - Range compares include the lower and exclude the upper bound.
module pib_bridge #(
  parameter int REF_SLOW_CYC = `PIB_SLOW_REF_NS / `PIB_CLK_NS,
  parameter int REF_NORM_CYC = `PIB_NORM_REF_NS / `PIB_CLK_NS,
  parameter int ADDR_W       = 27
) (
  input  wire logic              I_MCLK,          // PCI clock, 100 MHz
  input  wire logic              I_RST_N,         // Asynchronous reset, active low
  input  wire logic              I_CFG_WR,        // Configuration byte write strobe
  input  wire logic              I_CFG_RD,        // Configuration byte read strobe
  input  wire logic [7:0]        I_CFG_ADDR,      // Configuration byte offset
  input  wire logic [7:0]        I_CFG_WDATA,     // Configuration write byte
  output logic      [7:0]        O_CFG_RDATA,     // Configuration read byte
  input  wire logic              I_IO_STROBE,     // PCI I/O cycle seen, one cycle
  input  wire logic [3:0]        I_IO_BE_N,       // Byte enables of that cycle
  output logic                   O_TARGET_ABORT,  // Target abort pulse
  output logic                   O_SERR_N,        // System error, active low
  output logic                   O_SERR_OE,       // System error drive enable
  input  wire logic              I_IOCHK_N,       // ISA channel check, active low
  output logic                   O_SYSCLK,        // ISA bus clock
  output logic                   O_SYSCLK_EN,     // One-cycle ISA clock enable
  input  wire logic              I_IO_REQ,        // ISA I/O command wanted
  input  wire logic              I_IO_16B,        // Wanted command is 16-bit
  input  wire logic              I_IO_SUB,        // Sub-cycle of the last access
  input  wire logic              I_IO_CMD_DONE,   // Command ended, one cycle
  output logic                   O_IO_GRANT,      // Command may start now
  output logic                   O_PASSIVE_REL,   // Passive release enabled
  output logic                   O_REFRESH_OPT,   // Refresh option enabled
  output logic                   O_REFRESH_REQ,   // Refresh request pulse
  input  wire logic              I_ISA_MEM,       // ISA master or DMA memory cycle
  input  wire logic              I_ISA_IO,        // ISA master or DMA I/O cycle
  input  wire logic [ADDR_W-1:0] I_ISA_ADDR,      // Its address
  output logic                   O_FWD_PCI        // Forward the cycle to PCI
);

  logic        serr_en_r;
  logic        sta_r;
  logic        sse_r;
  logic [7:0]  io_recovery_timing_r;
  logic [7:0]  misc_r;
  logic [7:0]  tom_r;
  logic        chk_r;
  logic        chk_d_r;
  logic        ble_r;
  logic        abort_r;
  logic        serr_r;
  logic [1:0]  div_r;
  logic        sysclk_r;
  logic [5:0]  rec_cnt_r;
  logic [5:0]  rec_nxt;
  logic        last_16b_r;
  logic [31:0] ref_cnt_r;
  logic        ref_r;
  logic [7:0]  rdata_nxt;
  logic        lane_bad;
  logic        serr_evt;
  logic        wr_sts_hi;
  logic [3:0]  extra8;
  logic [3:0]  extra16;
  logic [ADDR_W-1:0] top_addr;
  pib_pkg::pib_rec_type rec_r;

  // Non-contiguous enabled lanes cannot be split into legal ISA cycles.
  always_comb begin
    unique case (I_IO_BE_N)
      4'hA, 4'h5, 4'h6, 4'h4, 4'h2: lane_bad = 1'b1;
      default:                      lane_bad = 1'b0;
    endcase
  end

  assign serr_evt  = serr_en_r & ((I_IO_STROBE & lane_bad) | (chk_r & ~chk_d_r)); // see RQ12 RQ13 RQ23
  assign wr_sts_hi = I_CFG_WR && (I_CFG_ADDR == `PIB_OFS_STS_HI);

  // Only the driver enable of the command high byte is writable; the rest is hardwired.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      serr_en_r <= 1'b0;
    end else if (I_CFG_WR && (I_CFG_ADDR == `PIB_OFS_CMD_HI)) begin
      serr_en_r <= I_CFG_WDATA[`PIB_CMD_SERR_BIT]; // see RQ23
    end
  end

  // The reserved divider bit is kept as written, since it changes nothing in the logic.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      io_recovery_timing_r <= `PIB_IO_RECOVERY_TIMING_RST;
    end else if (I_CFG_WR && (I_CFG_ADDR == `PIB_OFS_IO_RECOVERY_TIMING)) begin
      io_recovery_timing_r <= I_CFG_WDATA;
    end
  end

  // Reserved control bits are masked on the way in, so they always read zero.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      misc_r <= `PIB_MISC_RST;
    end else if (I_CFG_WR && (I_CFG_ADDR == `PIB_OFS_MISC)) begin
      misc_r <= I_CFG_WDATA & `PIB_MISC_MASK; // see RQ9 RQ26
    end
  end

  // A new ceiling applies to the very next cycle that an ISA master or DMA drives.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tom_r <= `PIB_TOM_RST;
    end else if (I_CFG_WR && (I_CFG_ADDR == `PIB_OFS_TOM)) begin
      tom_r <= I_CFG_WDATA & `PIB_TOM_MASK; // see RQ26
    end
  end

  // Hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sta_r <= 1'b0;
      sse_r <= 1'b0;
    end else begin
      if (I_IO_STROBE && lane_bad) begin
        sta_r <= 1'b1; // see RQ25
      end else if (wr_sts_hi && I_CFG_WDATA[`PIB_STS_STA_BIT]) begin
        sta_r <= 1'b0;
      end
      if (serr_evt) begin
        sse_r <= 1'b1; // see RQ24
      end else if (wr_sts_hi && I_CFG_WDATA[`PIB_STS_SSE_BIT]) begin
        sse_r <= 1'b0;
      end
    end
  end

  // The lane error flag stays until a legal I/O cycle replaces it.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      chk_r   <= 1'b0;
      chk_d_r <= 1'b0;
      ble_r   <= 1'b0;
      abort_r <= 1'b0;
      serr_r  <= 1'b0;
    end else begin
      chk_r   <= ~I_IOCHK_N; // see RQ11
      chk_d_r <= chk_r;
      abort_r <= I_IO_STROBE & lane_bad; // see RQ13
      serr_r  <= serr_evt;
      if (I_IO_STROBE) begin
        ble_r <= lane_bad; // see RQ13
      end
    end
  end

  assign O_TARGET_ABORT = abort_r;
  assign O_SERR_N       = ~serr_r;
  assign O_SERR_OE      = serr_r;

  always_comb begin
    rdata_nxt = `PIB_ZERO8; // see RQ26
    unique case (I_CFG_ADDR)
      `PIB_OFS_CMD_LO: rdata_nxt = `PIB_CMD_LO_VAL;
      `PIB_OFS_CMD_HI: rdata_nxt[`PIB_CMD_SERR_BIT] = serr_en_r;
      `PIB_OFS_STS_LO: rdata_nxt = `PIB_STS_LO_VAL;
      `PIB_OFS_STS_HI: begin
        rdata_nxt[`PIB_STS_DEVSEL_BIT] = 1'b1;
        rdata_nxt[`PIB_STS_STA_BIT]    = sta_r;
        rdata_nxt[`PIB_STS_SSE_BIT]    = sse_r;
      end
      `PIB_OFS_HDR:    rdata_nxt = `PIB_HDR_VAL; // see RQ1
      `PIB_OFS_IO_RECOVERY_TIMING:   rdata_nxt = io_recovery_timing_r;
      `PIB_OFS_MISC:   rdata_nxt = misc_r;
      `PIB_OFS_ISTS: begin
        rdata_nxt[`PIB_ISTS_CHK_BIT] = chk_r; // see RQ11
        rdata_nxt[`PIB_ISTS_BLE_BIT] = ble_r;
      end
      `PIB_OFS_TOM:    rdata_nxt = tom_r;
      default:         ;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CFG_RDATA <= `PIB_ZERO8;
    end else if (I_CFG_RD) begin
      O_CFG_RDATA <= rdata_nxt;
    end
  end

  // The reserved divider setting still divides by four, so the bus never stops.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_r    <= 2'h0;
      sysclk_r <= 1'b0;
    end else begin
      div_r    <= div_r + 2'h1; // see RQ4
      sysclk_r <= div_r[1];
    end
  end

  assign O_SYSCLK    = sysclk_r;
  assign O_SYSCLK_EN = (div_r == `PIB_DIV_LAST);

  // Programmed clocks are added on top of the fixed 3.5-clock floor.
  always_comb begin
    extra8  = 4'h0;
    extra16 = 4'h0;
    if (io_recovery_timing_r[`PIB_IO_RECOVERY_TIMING_8EN_BIT]) begin // see RQ5
      unique case (io_recovery_timing_r[`PIB_IO_RECOVERY_TIMING_8_HI:`PIB_IO_RECOVERY_TIMING_8_LO])
        3'h0:    extra8 = 4'h8; // see RQ6
        3'h5:    extra8 = 4'h4;
        default: extra8 = {1'b0, io_recovery_timing_r[`PIB_IO_RECOVERY_TIMING_8_HI:`PIB_IO_RECOVERY_TIMING_8_LO]};
      endcase
    end
    if (io_recovery_timing_r[`PIB_IO_RECOVERY_TIMING_16EN_BIT]) begin // see RQ7
      extra16 = (io_recovery_timing_r[`PIB_IO_RECOVERY_TIMING_16_HI:`PIB_IO_RECOVERY_TIMING_16_LO] == 2'h0) ? 4'h4 :
                {2'h0, io_recovery_timing_r[`PIB_IO_RECOVERY_TIMING_16_HI:`PIB_IO_RECOVERY_TIMING_16_LO]}; // see RQ8
    end
  end

  // Recovery counts PCI clocks: two per half ISA clock, four per added clock.
  assign rec_nxt = 6'(`PIB_BASE_RECOV_HALF * 2)
                 + {(last_16b_r ? extra16 : extra8), 2'h0}; // see RQ2

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rec_r      <= pib_pkg::REC_IDLE;
      rec_cnt_r  <= 6'h00;
      last_16b_r <= 1'b0;
    end else begin
      unique case (rec_r)
        pib_pkg::REC_IDLE: if (O_IO_GRANT) begin
          rec_r      <= pib_pkg::REC_CMD;
          last_16b_r <= I_IO_16B;
        end
        pib_pkg::REC_CMD: if (I_IO_CMD_DONE) begin
          rec_r     <= pib_pkg::REC_WAIT;
          rec_cnt_r <= rec_nxt - 6'h01;
        end
        pib_pkg::REC_WAIT: begin
          if (O_IO_GRANT) begin
            rec_r      <= pib_pkg::REC_CMD;
            last_16b_r <= I_IO_16B;
          end else if (rec_cnt_r == 6'h00) begin
            rec_r <= pib_pkg::REC_IDLE;
          end else begin
            rec_cnt_r <= rec_cnt_r - 6'h01;
          end
        end
      endcase
    end
  end

  assign O_IO_GRANT = I_IO_REQ && ((rec_r == pib_pkg::REC_IDLE) ||
                      ((rec_r == pib_pkg::REC_WAIT) && I_IO_SUB)); // see RQ2 RQ3

  assign O_PASSIVE_REL = misc_r[`PIB_MISC_PREL_BIT]; // see RQ9
  assign O_REFRESH_OPT = misc_r[`PIB_MISC_REFO_BIT];

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ref_cnt_r <= 32'h0000_0000;
      ref_r     <= 1'b0;
    end else begin
      ref_r <= 1'b0;
      if (ref_cnt_r == 32'h0000_0000) begin
        ref_cnt_r <= misc_r[`PIB_MISC_SLOW_BIT] ? 32'(REF_SLOW_CYC - 1)
                                                : 32'(REF_NORM_CYC - 1); // see RQ10
        ref_r     <= 1'b1;
      end else begin
        ref_cnt_r <= ref_cnt_r - 32'h0000_0001;
      end
    end
  end

  assign O_REFRESH_REQ = ref_r;

  // Top of memory is one Mbyte above the field value.
  // The field is widened by one bit first so that the largest value still gives 16 Mbytes.
  assign top_addr = ADDR_W'({1'b0, tom_r[`PIB_TOM_TOP_HI:`PIB_TOM_TOP_LO]} + 5'h01)
                    << `PIB_MB_SHIFT; // see RQ14

  always_comb begin
    O_FWD_PCI = 1'b0;
    if (I_ISA_MEM && !I_ISA_IO) begin // see RQ22
      if (I_ISA_ADDR >= top_addr) begin
        O_FWD_PCI = 1'b0; // see RQ19
      end else if (I_ISA_ADDR >= ADDR_W'(`PIB_A_1M)) begin
        O_FWD_PCI = 1'b1; // see RQ20
      end else if (I_ISA_ADDR >= ADDR_W'(`PIB_A_F0000)) begin
        O_FWD_PCI = 1'b1; // see RQ21
      end else if (I_ISA_ADDR >= ADDR_W'(`PIB_A_E0000)) begin
        O_FWD_PCI = tom_r[`PIB_TOM_E_BIT]; // see RQ16 RQ27
      end else if (I_ISA_ADDR >= ADDR_W'(`PIB_A_768K)) begin
        O_FWD_PCI = 1'b1; // see RQ21
      end else if (I_ISA_ADDR >= ADDR_W'(`PIB_A_640K)) begin
        O_FWD_PCI = tom_r[`PIB_TOM_A_BIT]; // see RQ17
      end else if (I_ISA_ADDR >= ADDR_W'(`PIB_A_512K)) begin
        O_FWD_PCI = tom_r[`PIB_TOM_8_BIT]; // see RQ18
      end else begin
        O_FWD_PCI = 1'b1; // see RQ21
      end
    end
  end

endmodule // pib_bridge

`default_nettype wire

// >>> pib_params.svh
// Register offsets, field positions, reset values and timing constants of the bridge.
`ifndef PIB_PARAMS_SVH
`define PIB_PARAMS_SVH

`define PIB_OFS_CMD_LO      8'h04
`define PIB_OFS_CMD_HI      8'h05
`define PIB_OFS_STS_LO      8'h06
`define PIB_OFS_STS_HI      8'h07
`define PIB_OFS_HDR         8'h0E
`define PIB_OFS_IO_RECOVERY_TIMING        8'h40
`define PIB_OFS_MISC        8'h41
`define PIB_OFS_ISTS        8'h42
`define PIB_OFS_TOM         8'h43

`define PIB_HDR_VAL         8'h00
`define PIB_CMD_LO_VAL      8'h07
`define PIB_STS_LO_VAL      8'h00
`define PIB_IO_RECOVERY_TIMING_RST        8'h4D
`define PIB_MISC_RST        8'h00
`define PIB_TOM_RST         8'h0E
`define PIB_MISC_MASK       8'h83
`define PIB_TOM_MASK        8'hFE
`define PIB_ZERO8           8'h00

`define PIB_CMD_SERR_BIT    0
`define PIB_STS_DEVSEL_BIT  1
`define PIB_STS_STA_BIT     3
`define PIB_STS_SSE_BIT     6
`define PIB_IO_RECOVERY_TIMING_DIV_BIT    7
`define PIB_IO_RECOVERY_TIMING_8EN_BIT    6
`define PIB_IO_RECOVERY_TIMING_8_HI       5
`define PIB_IO_RECOVERY_TIMING_8_LO       3
`define PIB_IO_RECOVERY_TIMING_16EN_BIT   2
`define PIB_IO_RECOVERY_TIMING_16_HI      1
`define PIB_IO_RECOVERY_TIMING_16_LO      0
`define PIB_MISC_PREL_BIT   7
`define PIB_MISC_SLOW_BIT   1
`define PIB_MISC_REFO_BIT   0
`define PIB_ISTS_CHK_BIT    2
`define PIB_ISTS_BLE_BIT    0
`define PIB_TOM_TOP_HI      7
`define PIB_TOM_TOP_LO      4
`define PIB_TOM_E_BIT       3
`define PIB_TOM_A_BIT       2
`define PIB_TOM_8_BIT       1

`define PIB_CLK_NS          10
`define PIB_ISA_DIV         4
`define PIB_DIV_LAST        2'h3
`define PIB_BASE_RECOV_HALF 7
`define PIB_SLOW_REF_NS     208000
`define PIB_NORM_REF_NS     15000

`define PIB_A_512K          27'h0080000
`define PIB_A_640K          27'h00A0000
`define PIB_A_768K          27'h00C0000
`define PIB_A_E0000         27'h00E0000
`define PIB_A_F0000         27'h00F0000
`define PIB_A_1M            27'h0100000
`define PIB_MB_SHIFT        20

`endif

// >>> pib_pkg.sv
// Types shared by the bridge configuration and decode logic.
package pib_pkg;
  typedef enum logic [1:0] {REC_IDLE, REC_CMD, REC_WAIT} pib_rec_type;
endpackage

// >>> pib_bridge_props.sv
// Concurrent checks on the ports of the bridge configuration and decode block.
`timescale 1ns/1ns
`default_nettype none
module pib_bridge_props #(
  parameter int ADDR_W = 27
) (
  input wire logic              I_MCLK,
  input wire logic              I_RST_N,
  input wire logic              I_IO_STROBE,
  input wire logic [3:0]        I_IO_BE_N,
  input wire logic              O_TARGET_ABORT,
  input wire logic              O_SERR_N,
  input wire logic              O_SERR_OE,
  input wire logic              O_SYSCLK,
  input wire logic              O_SYSCLK_EN,
  input wire logic              I_IO_REQ,
  input wire logic              I_IO_SUB,
  input wire logic              I_IO_CMD_DONE,
  input wire logic              O_IO_GRANT,
  input wire logic              I_ISA_MEM,
  input wire logic              I_ISA_IO,
  input wire logic [ADDR_W-1:0] I_ISA_ADDR,
  input wire logic              O_FWD_PCI
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  AST_ILLEGAL_ABORT: assert property (I_IO_STROBE && I_IO_BE_N inside {4'hA, 4'h5, 4'h6, 4'h4, 4'h2}
    |=> O_TARGET_ABORT) else $error("no abort after illegal lanes");
  AST_NO_STRAY_ABORT: assert property (!(I_IO_STROBE && I_IO_BE_N inside {4'hA, 4'h5, 4'h6,
    4'h4, 4'h2}) |=> !O_TARGET_ABORT) else $error("abort without cause");
  AST_SERR_PULSE: assert property ($fell(O_SERR_N) |-> O_SERR_OE ##1 (O_SERR_N && !O_SERR_OE))
    else $error("system error pulse malformed");
  AST_SYSCLK_DIV: assert property ($rose(O_SYSCLK) |-> ##4 $rose(O_SYSCLK))
    else $error("bus clock not a quarter rate");
  AST_SYSCLK_EN: assert property (O_SYSCLK_EN |=> !O_SYSCLK_EN [*3] ##1 O_SYSCLK_EN)
    else $error("bus clock enable spacing wrong");
  // Fourteen cycles is the 3.5 bus clock floor at the quarter rate.
  AST_RECOVERY_FLOOR: assert property (I_IO_CMD_DONE |=> (!O_IO_GRANT || I_IO_SUB) [*8] ##1
    (!O_IO_GRANT || I_IO_SUB) [*6]) else $error("command granted inside recovery");
  AST_SUB_NO_WAIT: assert property (I_IO_CMD_DONE ##1 (I_IO_REQ && I_IO_SUB) |-> O_IO_GRANT)
    else $error("sub-cycle delayed");
  AST_IO_NOT_FWD: assert property (I_ISA_IO |-> !O_FWD_PCI)
    else $error("I/O cycle forwarded");
  AST_LOW_FWD: assert property (I_ISA_MEM && !I_ISA_IO && I_ISA_ADDR < 27'h0080000 |-> O_FWD_PCI)
    else $error("low memory not forwarded");
  AST_HIGH_ISA: assert property (I_ISA_MEM && I_ISA_ADDR >= 27'h1000000 |-> !O_FWD_PCI)
    else $error("memory above ceiling forwarded");
endmodule // pib_bridge_props

bind pib_bridge pib_bridge_props #(.ADDR_W(ADDR_W)) u_props (
  .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_IO_STROBE(I_IO_STROBE), .I_IO_BE_N(I_IO_BE_N),
  .O_TARGET_ABORT(O_TARGET_ABORT), .O_SERR_N(O_SERR_N), .O_SERR_OE(O_SERR_OE),
  .O_SYSCLK(O_SYSCLK), .O_SYSCLK_EN(O_SYSCLK_EN), .I_IO_REQ(I_IO_REQ), .I_IO_SUB(I_IO_SUB),
  .I_IO_CMD_DONE(I_IO_CMD_DONE), .O_IO_GRANT(O_IO_GRANT), .I_ISA_MEM(I_ISA_MEM),
  .I_ISA_IO(I_ISA_IO), .I_ISA_ADDR(I_ISA_ADDR), .O_FWD_PCI(O_FWD_PCI));
`default_nettype wire

// >>> pib_isa_slave.sv
// Behavioural ISA I/O slave that ends each granted command after a set time.
`timescale 1ns/1ns
`default_nettype none
module pib_isa_slave #(
  parameter int CMD_CYC = 3
) (
  input  wire logic i_clk,   // Clock
  input  wire logic i_rst_n, // Reset, active low
  input  wire logic i_take,  // Command starts on this edge
  output logic      o_done   // Command end, one cycle
);
  int cnt_r;

  // A larger CMD_CYC models a slow slave holding the command longer.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= 0;
      o_done <= 1'h0;
    end else begin
      o_done <= (cnt_r == 1);
      if (i_take) cnt_r <= CMD_CYC;
      else if (cnt_r != 0) cnt_r <= cnt_r - 1;
    end
  end
endmodule // pib_isa_slave
`default_nettype wire

// >>> pib_bridge_test.sv
// Self-checking bench for the bridge registers, recovery timing and forwarding decode.
`include "pib_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pib_bridge_test;
  typedef struct {logic [7:0] dma_memory_ceiling; logic [26:0] adr; logic fwd;} pib_dec_type;
  typedef struct {logic [7:0] io_recovery_timing; logic w16; logic sub; int gap;} pib_gap_type;
  logic        clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, stb = 1'h0, chk_n = 1'h1;
  logic        req = 1'h0, w16 = 1'h0, sub = 1'h0, mem = 1'h0, isa_io = 1'h0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, cur_tom;
  logic [3:0]  be_n = 4'hF;
  logic [26:0] adr = 27'h0000000;
  logic        abort, serr_n, serr_oe, sysclk, sysclk_en, grant, prel, refo, refq, fwd, done;
  int          err_total = 0, checks_done = 0, k, n, pn, ps;
  pib_dec_type dec [23] = '{
    '{8'h0E, 27'h0000000, 1'h1}, '{8'h0E, 27'h007FFFF, 1'h1}, '{8'h0E, 27'h0080000, 1'h1},
    '{8'h0E, 27'h00A0000, 1'h1}, '{8'h0E, 27'h00E0000, 1'h1}, '{8'h0E, 27'h00FFFFF, 1'h1},
    '{8'h0E, 27'h0100000, 1'h0}, '{8'h00, 27'h007FFFF, 1'h1}, '{8'h00, 27'h0080000, 1'h0},
    '{8'h00, 27'h009FFFF, 1'h0}, '{8'h00, 27'h00A0000, 1'h0}, '{8'h00, 27'h00BFFFF, 1'h0},
    '{8'h00, 27'h00C0000, 1'h1}, '{8'h00, 27'h00DFFFF, 1'h1}, '{8'h00, 27'h00E0000, 1'h0},
    '{8'h00, 27'h00EFFFF, 1'h0}, '{8'h00, 27'h00F0000, 1'h1},
    '{8'hE0, 27'h0EFFFFF, 1'h1}, '{8'hE0, 27'h0F00000, 1'h0}, // Hole at 15 MB
    '{8'hF0, 27'h0FFFFFF, 1'h1}, '{8'hF0, 27'h1000000, 1'h0}, '{8'hF0, 27'h7FFFFFF, 1'h0},
    '{8'h0E, 27'h0000000, 1'h1}};
  pib_gap_type rec [15] = '{
    '{8'h4D, 1'h0, 1'h0, 19}, '{8'h4D, 1'h1, 1'h0, 19}, '{8'h09, 1'h0, 1'h0, 15},
    '{8'h09, 1'h1, 1'h0, 15}, '{8'h40, 1'h0, 1'h0, 47}, '{8'h50, 1'h0, 1'h0, 23},
    '{8'h58, 1'h0, 1'h0, 27}, '{8'h60, 1'h0, 1'h0, 31}, '{8'h68, 1'h0, 1'h0, 31},
    '{8'h70, 1'h0, 1'h0, 39}, '{8'h78, 1'h0, 1'h0, 43}, '{8'h44, 1'h1, 1'h0, 31},
    '{8'h46, 1'h1, 1'h0, 23}, '{8'h47, 1'h1, 1'h0, 27}, '{8'h4D, 1'h0, 1'h1, 1}};

  pib_bridge #(.REF_SLOW_CYC(40), .REF_NORM_CYC(20)) uut (
    .I_MCLK(clk), .I_RST_N(rst_n), .I_CFG_WR(wr), .I_CFG_RD(rd), .I_CFG_ADDR(addr),
    .I_CFG_WDATA(wdata), .O_CFG_RDATA(rdata), .I_IO_STROBE(stb), .I_IO_BE_N(be_n),
    .O_TARGET_ABORT(abort), .O_SERR_N(serr_n), .O_SERR_OE(serr_oe), .I_IOCHK_N(chk_n),
    .O_SYSCLK(sysclk), .O_SYSCLK_EN(sysclk_en), .I_IO_REQ(req), .I_IO_16B(w16),
    .I_IO_SUB(sub), .I_IO_CMD_DONE(done), .O_IO_GRANT(grant), .O_PASSIVE_REL(prel),
    .O_REFRESH_OPT(refo), .O_REFRESH_REQ(refq), .I_ISA_MEM(mem), .I_ISA_IO(isa_io),
    .I_ISA_ADDR(adr), .O_FWD_PCI(fwd));
  pib_isa_slave #(.CMD_CYC(3)) u_slave (.i_clk(clk), .i_rst_n(rst_n), .i_take(grant),
    .o_done(done));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tmo(input int cnt);
    if (cnt >= 200) begin
      err_total++;
      close_out();
    end
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic cfg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    chk("config read", exp, rdata);
  endtask

  task automatic io_cyc(input logic [3:0] lanes, input logic ab, input logic sn);
    @(posedge clk);
    stb <= 1'h1;
    be_n <= lanes;
    @(posedge clk);
    stb <= 1'h0;
    @(negedge clk);
    chk("target abort", ab, abort);
    chk("system error", sn, serr_n);
  endtask

  task automatic ref_period(output int p);
    for (k = 0; k < 200 && refq !== 1'h1; k++) @(negedge clk);
    tmo(k);
    @(negedge clk);
    for (p = 1; p < 200 && refq !== 1'h1; p++) @(negedge clk);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    chk("reset outputs", 3'h0, {prel, refo, serr_oe});
    cfg_rd(`PIB_OFS_IO_RECOVERY_TIMING, 8'h4D);
    cfg_rd(`PIB_OFS_TOM, 8'h0E);
    cfg_rd(`PIB_OFS_MISC, 8'h00);
    cfg_wr(`PIB_OFS_HDR, 8'hFF);
    cfg_rd(`PIB_OFS_HDR, 8'h00);
    cfg_wr(`PIB_OFS_ISTS, 8'hFF);
    cfg_rd(`PIB_OFS_ISTS, 8'h00);
    cfg_rd(8'h44, 8'h00);
    cfg_wr(`PIB_OFS_MISC, 8'hFF);
    cfg_rd(`PIB_OFS_MISC, 8'h83);
    chk("control outputs", 2'h3, {prel, refo});
    cfg_wr(`PIB_OFS_TOM, 8'hFF);
    cfg_rd(`PIB_OFS_TOM, 8'hFE);
    cur_tom = 8'hFE;
    foreach (dec[i]) begin
      if (dec[i].dma_memory_ceiling !== cur_tom) cfg_wr(`PIB_OFS_TOM, dec[i].dma_memory_ceiling);
      cur_tom = dec[i].dma_memory_ceiling;
      @(posedge clk);
      mem <= 1'h1;
      adr <= dec[i].adr;
      @(negedge clk);
      chk("forward", dec[i].fwd, fwd);
    end
    @(posedge clk);
    adr <= 27'h0000000;
    isa_io <= 1'h1;
    @(negedge clk);
    chk("io forward", 1'h0, fwd);
    foreach (rec[i]) begin
      cfg_wr(`PIB_OFS_IO_RECOVERY_TIMING, rec[i].io_recovery_timing);
      @(posedge clk);
      req <= 1'h1;
      w16 <= rec[i].w16;
      sub <= rec[i].sub;
      for (k = 0; k < 200 && done !== 1'h1; k++) @(negedge clk);
      tmo(k);
      for (n = 1; n < 200; n++) begin
        @(negedge clk);
        if (grant === 1'h1) break;
      end
      chk("recovery gap", rec[i].gap, n);
      @(posedge clk);
      req <= 1'h0;
      repeat (80) @(posedge clk);
    end
    cfg_wr(`PIB_OFS_CMD_HI, 8'h01);
    foreach (dec[i]) if (i < 5) io_cyc(4'(32'h2456A >> (4 * i)), 1'h1, 1'h0);
    cfg_rd(`PIB_OFS_STS_HI, 8'h4A);
    cfg_rd(`PIB_OFS_ISTS, 8'h01);
    cfg_wr(`PIB_OFS_STS_HI, 8'h48);
    cfg_rd(`PIB_OFS_STS_HI, 8'h02);
    io_cyc(4'hE, 1'h0, 1'h1);
    cfg_rd(`PIB_OFS_ISTS, 8'h00);
    @(posedge clk);
    chk_n <= 1'h0;
    for (k = 0; k < 6 && serr_n !== 1'h0; k++) @(negedge clk);
    chk("check pulse", 1'h1, k < 6);
    cfg_rd(`PIB_OFS_ISTS, 8'h04);
    @(posedge clk);
    chk_n <= 1'h1;
    cfg_wr(`PIB_OFS_STS_HI, 8'h48);
    cfg_wr(`PIB_OFS_CMD_HI, 8'h00);
    io_cyc(4'hA, 1'h1, 1'h1);
    cfg_rd(`PIB_OFS_STS_HI, 8'h0A);
    cfg_wr(`PIB_OFS_MISC, 8'h00);
    ref_period(pn);
    cfg_wr(`PIB_OFS_MISC, 8'h02);
    ref_period(ps);
    ref_period(ps);
    chk("slow refresh", 20, ps - pn);
    close_out();
  end
endmodule // pib_bridge_test
`default_nettype wire
